// ===== pkg/uart_core_pkg.sv
// shared constants, types and helpers of the serial core
package uart_core_pkg;

  // register index map
  localparam logic [2:0] REG_DATA   = 3'h0;
  localparam logic [2:0] REG_CTRL1  = 3'h1;
  localparam logic [2:0] REG_CTRL2  = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_BAUD   = 3'h4;

  // control 1 field positions
  localparam int C1_RX9  = 7;
  localparam int C1_TX9  = 6;
  localparam int C1_M9   = 4;
  localparam int C1_WAKE = 3;

  // control 2 field positions
  localparam int C2_TXIE = 7;
  localparam int C2_TCIE = 6;
  localparam int C2_RXIE = 5;
  localparam int C2_ILIE = 4;
  localparam int C2_TXEN = 3;
  localparam int C2_RXEN = 2;
  localparam int C2_SLP  = 1;
  localparam int C2_BRK  = 0;

  // status field positions
  localparam int ST_TXMT = 7;
  localparam int ST_TXDN = 6;
  localparam int ST_RXF  = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR  = 3;
  localparam int ST_NSE  = 2;
  localparam int ST_FRM  = 1;

  // receive sample positions within a bit, in sixteenths
  localparam logic [3:0] VER_A = 4'h3;
  localparam logic [3:0] VER_B = 4'h5;
  localparam logic [3:0] VER_C = 4'h7;
  localparam logic [3:0] MID_A = 4'h8;
  localparam logic [3:0] MID_B = 4'h9;
  localparam logic [3:0] MID_C = 4'hA;
  localparam logic [3:0] LAST_PH = 4'hF;

  // frame lengths and reset values
  localparam logic [3:0] BITS_8 = 4'hA;
  localparam logic [3:0] BITS_9 = 4'hB;
  localparam logic [4:0] BAUD_SEL_RST = 5'h00;
  localparam int BAUD_BASE_DIV = 4;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_VERIFY, RX_FRAME} rx_state_t;

  typedef struct packed {
    logic       tx_int_en;
    logic       tc_int_en;
    logic       rx_int_en;
    logic       idle_int_en;
    logic       tx_enable_bit;
    logic       rx_enable;
    logic       rx_wake_sleep;
    logic       send_break;
  } ctrl_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic frame_error_flag;
  } flags_t;

  typedef struct packed {
    logic [7:0] tx_data;
    logic       t8;
    logic       r8;
    logic       word9;
    logic       wake_addr;
    ctrl_t      ctrl;
    logic [4:0] baud_sel;
    logic [7:0] rx_data;
    flags_t     fl;
    logic       status_armed;
    logic [7:0] rdata;
    tx_state_t  tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_phase;
    logic       tx_enable_prev;
    logic       preamble_due;
    logic       tx_line;
    logic       tx_oe;
    rx_state_t  rx_state;
    logic [3:0] rx_phase;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic [1:0] ver_lows;
    logic [2:0] votes;
    logic       rx_noise;
    logic       line_seen_high;
    logic [7:0] idle_ticks;
    logic       idle_armed;
    logic       irq;
  } core_t;

  localparam flags_t FLAGS_RST = 7'h60;

  localparam core_t CORE_RST = '{tx_state: TX_IDLE, rx_state: RX_IDLE,
    fl: FLAGS_RST, tx_line: 1'b1, baud_sel: BAUD_SEL_RST, default: '0};

  typedef struct packed {
    logic [1:0] stages;
  } rst_sync_t;

  function automatic logic majority3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [3:0] frame_bits(input logic nine);
    return nine ? BITS_9 : BITS_8;
  endfunction

endpackage

// ===== rtl/reset_sync.sv
// two-stage release of the asynchronous reset
module reset_sync
  import uart_core_pkg::*;
(
  // clock and raw reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // released copy
  output logic      rst_sync_n
);

  rst_sync_t s;
  rst_sync_t next_s;

  always_comb
  begin
    next_s.stages = {s.stages[0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign rst_sync_n = s.stages[1];

endmodule

// ===== rtl/baud_tick_gen.sv
// selectable divider for the sixteen-per-bit sample tick
module baud_tick_gen
  import uart_core_pkg::*;
#(
  parameter int BASE_DIV = BAUD_BASE_DIV
)
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // rate select and tick
  input  wire logic [4:0] baud_sel,
  output logic            rx_sample_tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } baud_state_t;

  baud_state_t s;
  baud_state_t next_s;
  logic [15:0] limit;

  always_comb
  begin
    limit = 16'(({11'h000, baud_sel} + 16'h0001) * 16'(BASE_DIV)) - 16'h0001;
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt >= limit)
    begin
      next_s.cnt = 16'h0000;
      next_s.tick = 1'b1;
    end
    else
      next_s.cnt = s.cnt + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign rx_sample_tick = s.tick;

endmodule

// ===== rtl/async_serial_rx_tx_core.sv
// full-duplex asynchronous serial core with register port
// Summary of operation
// - start, 8 or 9 data, stop
// - high is one, line idles high
// - data least significant bit first
// - stop bit high in last slot
// - break is whole frames of zeros
// - idle receiver samples at sixteen per bit
// - three verify samples, majority low starts
// - one high verify sample sets noise
// - receiver resynchronises on every start bit
// - majority of samples eight, nine, ten
// - disagreeing mid-bit samples set noise
// - sleep suppresses flags until idle run
// - set most significant bit wakes sleepers
// - independent transmitter and receiver enables
// - thirty-two rates feed both directions
// - idle, framing, noise, overrun, full status
// - empty, complete flags and break send
// - four enables gate the interrupt
// - wake bit is last data bit
// - enable rise sends idle preamble
//
// Strobed register access and the placing of the registers were decided locally.
module async_serial_rx_tx_core
  import uart_core_pkg::*;
#(
  parameter int BASE_DIV = BAUD_BASE_DIV
)
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // serial link
  input  wire logic       serial_rx_in,
  output logic            serial_tx_out,
  output logic            serial_tx_oe,
  // interrupt request
  output logic            sci_irq
);

  logic  rst_core_n;
  logic  rx_sample_tick;
  core_t s;
  core_t next_s;
  logic  bit_val;
  logic  msb;
  logic  deliver;
  logic  [7:0] idle_len;

  reset_sync u_reset_sync (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .rst_sync_n (rst_core_n)
  );

  // one rate select drives both directions
  baud_tick_gen #(.BASE_DIV(BASE_DIV)) u_baud_tick_gen (
    .ref_clk        (ref_clk),
    .rst_n          (rst_core_n),
    .baud_sel       (s.baud_sel),
    .rx_sample_tick (rx_sample_tick)
  );

  always_comb
  begin
    next_s = s;
    bit_val = 1'b0;
    msb = 1'b0;
    deliver = 1'b0;
    idle_len = {frame_bits(s.word9), 4'h0};

    // register reads, data one cycle later
    next_s.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_DATA:
        begin
          next_s.rdata = s.rx_data;
          if (s.status_armed)
          begin
            next_s.fl.rx_full_flag = 1'b0;
            next_s.fl.idle_flag = 1'b0;
            next_s.fl.overrun_flag = 1'b0;
            next_s.fl.noise_flag = 1'b0;
            next_s.fl.frame_error_flag = 1'b0;
            next_s.status_armed = 1'b0;
          end
        end
        REG_CTRL1:
        begin
          next_s.rdata[C1_RX9] = s.r8;
          next_s.rdata[C1_TX9] = s.t8;
          next_s.rdata[C1_M9] = s.word9;
          next_s.rdata[C1_WAKE] = s.wake_addr;
        end
        REG_CTRL2:
          next_s.rdata = s.ctrl;
        REG_STATUS:
        begin
          next_s.rdata[ST_TXMT] = s.fl.tx_empty;
          next_s.rdata[ST_TXDN] = s.fl.tx_done;
          next_s.rdata[ST_RXF] = s.fl.rx_full_flag;
          next_s.rdata[ST_IDLE] = s.fl.idle_flag;
          next_s.rdata[ST_OVR] = s.fl.overrun_flag;
          next_s.rdata[ST_NSE] = s.fl.noise_flag;
          next_s.rdata[ST_FRM] = s.fl.frame_error_flag;
          next_s.status_armed = 1'b1;
        end
        REG_BAUD:
          next_s.rdata = {3'h0, s.baud_sel};
        default:
          next_s.rdata = 8'h00;
      endcase
    end

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        REG_DATA:
        begin
          next_s.tx_data = reg_wdata;
          next_s.fl.tx_empty = 1'b0;
          next_s.fl.tx_done = 1'b0;
        end
        REG_CTRL1:
        begin
          next_s.t8 = reg_wdata[C1_TX9];
          next_s.word9 = reg_wdata[C1_M9];
          next_s.wake_addr = reg_wdata[C1_WAKE];
        end
        REG_CTRL2:
          next_s.ctrl = reg_wdata;
        REG_BAUD:
          next_s.baud_sel = reg_wdata[4:0];
        default:
          next_s.baud_sel = s.baud_sel;
      endcase
    end

    // transmitter
    next_s.tx_enable_prev = next_s.ctrl.tx_enable_bit;
    if (next_s.ctrl.tx_enable_bit && !s.tx_enable_prev)
      next_s.preamble_due = 1'b1;
    if (rx_sample_tick)
    begin
      unique case (s.tx_state)
        TX_IDLE:
        begin
          next_s.tx_phase = 4'h0;
          next_s.tx_bits = frame_bits(s.word9);
          if (!s.ctrl.tx_enable_bit)
            next_s.tx_state = TX_IDLE;
          else if (s.preamble_due)
          begin
            next_s.tx_shift = 11'h7FF;
            next_s.preamble_due = 1'b0;
            next_s.tx_state = TX_SEND;
          end
          else if (s.ctrl.send_break)
          begin
            next_s.tx_shift = 11'h000;
            next_s.tx_state = TX_SEND;
          end
          else if (!s.fl.tx_empty)
          begin
            // stop high, optional ninth, data, start low
            next_s.tx_shift = {1'b1, s.word9 ? s.t8 : 1'b1,
                               s.tx_data, 1'b0};
            next_s.fl.tx_empty = 1'b1;
            next_s.tx_state = TX_SEND;
          end
          else
            next_s.fl.tx_done = 1'b1;
        end
        TX_SEND:
        begin
          next_s.tx_phase = s.tx_phase + 4'h1;
          if (s.tx_phase == LAST_PH)
          begin
            next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
            next_s.tx_bits = s.tx_bits - 4'h1;
            if (s.tx_bits == 4'h1)
              next_s.tx_state = TX_IDLE;
          end
        end
      endcase
    end
    next_s.tx_line = (next_s.tx_state == TX_SEND) ?
                     next_s.tx_shift[0] : 1'b1;
    next_s.tx_oe = next_s.ctrl.tx_enable_bit ||
                   (next_s.tx_state == TX_SEND);

    // receiver
    if (!s.ctrl.rx_enable)
    begin
      next_s.rx_state = RX_IDLE;
      next_s.idle_ticks = 8'h00;
    end
    else if (rx_sample_tick)
    begin
      unique case (s.rx_state)
        RX_IDLE:
        begin
          if (serial_rx_in)
          begin
            next_s.line_seen_high = 1'b1;
            if (s.idle_ticks != idle_len)
              next_s.idle_ticks = s.idle_ticks + 8'h01;
            if (s.idle_ticks == idle_len - 8'h01)
            begin
              if (s.ctrl.rx_wake_sleep && !s.wake_addr)
                next_s.ctrl.rx_wake_sleep = 1'b0;
              else if (!s.ctrl.rx_wake_sleep && s.idle_armed)
              begin
                next_s.fl.idle_flag = 1'b1;
                next_s.idle_armed = 1'b0;
              end
            end
          end
          else
          begin
            next_s.idle_ticks = 8'h00;
            if (s.line_seen_high)
            begin
              next_s.rx_state = RX_VERIFY;
              next_s.rx_phase = 4'h1;
              next_s.ver_lows = 2'h0;
              next_s.rx_noise = 1'b0;
            end
          end
        end
        RX_VERIFY:
        begin
          next_s.rx_phase = s.rx_phase + 4'h1;
          if (s.rx_phase == VER_A - 4'h1 || s.rx_phase == VER_B - 4'h1 ||
              s.rx_phase == VER_C - 4'h1)
          begin
            if (!serial_rx_in)
              next_s.ver_lows = s.ver_lows + 2'h1;
            if (s.rx_phase == VER_C - 4'h1)
            begin
              if (next_s.ver_lows >= 2'h2)
              begin
                next_s.rx_state = RX_FRAME;
                next_s.rx_bit = 4'h0;
                next_s.rx_noise = (next_s.ver_lows == 2'h2);
              end
              else
                next_s.rx_state = RX_IDLE;
            end
          end
        end
        RX_FRAME:
        begin
          next_s.rx_phase = s.rx_phase + 4'h1;
          if (s.rx_phase == 4'h0)
            next_s.rx_bit = s.rx_bit + 4'h1;
          if (s.rx_phase == MID_A - 4'h1 || s.rx_phase == MID_B - 4'h1 ||
              s.rx_phase == MID_C - 4'h1)
            next_s.votes = {s.votes[1:0], serial_rx_in};
          if (s.rx_phase == MID_C)
          begin
            bit_val = majority3(s.votes);
            if (s.votes != 3'h0 && s.votes != 3'h7)
              next_s.rx_noise = 1'b1;
            if (s.rx_bit != 4'h0 &&
                s.rx_bit != frame_bits(s.word9) - 4'h1)
              next_s.rx_shift = {bit_val, s.rx_shift[8:1]};
            if (s.rx_bit == frame_bits(s.word9) - 4'h1)
            begin
              // last data bit sits on top in both lengths
              msb = s.rx_shift[8];
              deliver = !s.ctrl.rx_wake_sleep ||
                        (s.wake_addr && msb);
              if (s.ctrl.rx_wake_sleep && s.wake_addr && msb)
                next_s.ctrl.rx_wake_sleep = 1'b0;
              if (deliver)
              begin
                if (next_s.fl.rx_full_flag)
                  next_s.fl.overrun_flag = 1'b1;
                else
                begin
                  next_s.rx_data = s.word9 ? s.rx_shift[7:0] :
                                             s.rx_shift[8:1];
                  next_s.r8 = s.rx_shift[8];
                  next_s.fl.rx_full_flag = 1'b1;
                  next_s.fl.frame_error_flag = !bit_val;
                  next_s.fl.noise_flag = next_s.rx_noise;
                end
              end
              // break or bad stop; wait for a high line
              if (!bit_val)
                next_s.line_seen_high = 1'b0;
              next_s.idle_armed = 1'b1;
              next_s.idle_ticks = 8'h00;
              next_s.rx_state = RX_IDLE;
            end
          end
        end
        default:
          next_s.rx_state = RX_IDLE;
      endcase
    end

    // interrupt gating by four enables
    next_s.irq = (next_s.ctrl.tx_int_en & next_s.fl.tx_empty) |
                 (next_s.ctrl.tc_int_en & next_s.fl.tx_done) |
                 (next_s.ctrl.rx_int_en & (next_s.fl.rx_full_flag |
                  next_s.fl.overrun_flag)) |
                 (next_s.ctrl.idle_int_en & next_s.fl.idle_flag);
  end

  always_ff @(posedge ref_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
      s <= CORE_RST;
    else
      s <= next_s;
  end

  assign reg_rdata = s.rdata;
  assign serial_tx_out = s.tx_line;
  assign serial_tx_oe = s.tx_oe;
  assign sci_irq = s.irq;

endmodule

// ===== verif/uart_core_chk.sv
// port assertions of the serial core
module uart_core_chk
  import uart_core_pkg::*;
#(
  parameter int BASE_DIV = BAUD_BASE_DIV
)
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  // serial link
  input  wire logic       serial_tx_out,
  input  wire logic       serial_tx_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT_CLKS = 16 * BASE_DIV;
  localparam int PRE_CLKS = 10 * BIT_CLKS;
  logic [15:0] run_len;
  logic [15:0] oe_len;
  logic        prev_tx;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_len <= 16'h0000;
      oe_len  <= 16'h0000;
      prev_tx <= 1'b1;
    end
    else
    begin
      prev_tx <= serial_tx_out;
      if (serial_tx_out != prev_tx)
        run_len <= 16'h0000;
      else if (run_len != 16'hFFFF)
        run_len <= run_len + 16'h0001;
      if (!serial_tx_oe)
        oe_len <= 16'h0000;
      else if (oe_len != 16'hFFFF)
        oe_len <= oe_len + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_rdata_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero");
  a_unmapped_zero: assert property (
    $past(reg_rd) && $past(reg_addr) > REG_BAUD |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl1_spare: assert property (
    $past(reg_rd) && $past(reg_addr) == REG_CTRL1
    |-> reg_rdata[5] == 1'b0 && reg_rdata[2:0] == 3'h0)
    else $error("control 1 spare bits set");
  a_status_spare: assert property (
    $past(reg_rd) && $past(reg_addr) == REG_STATUS |-> !reg_rdata[0])
    else $error("status spare bit set");
  a_baud_spare: assert property (
    $past(reg_rd) && $past(reg_addr) == REG_BAUD |-> reg_rdata[7:5] == 3'h0)
    else $error("rate spare bits set");
  a_idle_high: assert property (
    !serial_tx_oe |-> serial_tx_out) else $error("undriven line not high");
  a_bit_len: assert property (
    $changed(serial_tx_out) |-> run_len >= BIT_CLKS - 1)
    else $error("transmit bit too short");
  a_preamble_ones: assert property (
    serial_tx_oe && oe_len < PRE_CLKS |-> serial_tx_out)
    else $error("preamble not all ones");
  a_oe_drop: assert property (
    $fell(serial_tx_oe) |-> serial_tx_out && $past(serial_tx_out))
    else $error("drive dropped inside frame");
endmodule

bind async_serial_rx_tx_core uart_core_chk #(.BASE_DIV(BASE_DIV)) chk (
  .ref_clk       (ref_clk),
  .rst_n         (rst_n),
  .reg_addr      (reg_addr),
  .reg_rd        (reg_rd),
  .reg_rdata     (reg_rdata),
  .serial_tx_out (serial_tx_out),
  .serial_tx_oe  (serial_tx_oe)
);

// ===== verif/serial_node_model.sv
// remote serial node: sends frames and decodes the core output
module serial_node_model
#(
  parameter int BIT_CLKS = 16
)
(
  // clock
  input  wire logic ref_clk,
  // core transmit side
  input  wire logic serial_tx_out,
  input  wire logic serial_tx_oe,
  input  wire logic nine,
  // core receive side
  output logic      serial_rx_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] got_word;
  logic       got_stop;
  int         n_got;

  task automatic hold(input logic v, input int n);
    @(posedge ref_clk);
    serial_rx_in <= v;
    repeat (n - 1) @(posedge ref_clk);
  endtask

  task automatic send(input logic [8:0] w, input logic nb9,
                      input logic stop, input int glitch);
    hold(1'b1, BIT_CLKS);
    if (glitch == 9)
    begin
      // one high verify sample inside the start bit
      hold(1'b0, 4);
      hold(1'b1, 1);
      hold(1'b0, BIT_CLKS - 5);
    end
    else
      hold(1'b0, BIT_CLKS);
    for (int i = 0; i < (nb9 ? 9 : 8); i++)
    begin
      hold(w[i], (i == glitch) ? 9 : BIT_CLKS);
      if (i == glitch)
      begin
        hold(!w[i], 1);
        hold(w[i], BIT_CLKS - 10);
      end
    end
    hold(stop, BIT_CLKS);
    hold(1'b1, 1);
  endtask

  initial
  begin
    logic [8:0] w;
    serial_rx_in = 1'b1;
    got_word = 9'h000;
    got_stop = 1'b0;
    n_got = 0;
    forever
    begin
      @(posedge ref_clk);
      if (serial_tx_oe && !serial_tx_out)
      begin
        w = 9'h000;
        repeat (BIT_CLKS / 2) @(posedge ref_clk);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
          repeat (BIT_CLKS) @(posedge ref_clk);
          w[i] = serial_tx_out;
        end
        repeat (BIT_CLKS) @(posedge ref_clk);
        got_stop = serial_tx_out;
        got_word = w;
        n_got++;
      end
    end
  end
endmodule

// ===== verif/async_serial_rx_tx_core_tb_top.sv
// register-level testbench of the serial core
module async_serial_rx_tx_core_tb_top
  import uart_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BASE = 1;
  localparam int BITC = 16 * BASE;
  logic       ref_clk;
  logic       rst_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_wr;
  logic       reg_rd;
  logic       serial_rx_in;
  logic       serial_tx_out;
  logic       serial_tx_oe;
  logic       sci_irq;
  logic       nine;
  int         n_errors;
  int         total_checks;

  async_serial_rx_tx_core #(.BASE_DIV(BASE)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_rx_in(serial_rx_in),
    .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe),
    .sci_irq(sci_irq));
  serial_node_model #(.BIT_CLKS(BITC)) node (
    .ref_clk(ref_clk), .serial_tx_out(serial_tx_out),
    .serial_tx_oe(serial_tx_oe), .nine(nine),
    .serial_rx_in(serial_rx_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [8:0] seen,
                       input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", {1'b0, reg_rdata}, {1'b0, e});
  endtask

  task automatic wait_tx;
    int n0;
    n0 = node.n_got;
    for (int i = 0; i < 4000 && node.n_got == n0; i++) @(posedge ref_clk);
    check("tx frame seen", 9'(node.n_got != n0), 9'h001);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    nine = 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(REG_STATUS, 8'hC0);
    rd(REG_BAUD, 8'h00);
    rd(3'h6, 8'h00);
    wr(REG_CTRL2, 8'h8C);
    repeat (3) @(posedge ref_clk);
    check("sci_irq", 9'(sci_irq), 9'h001);
    wr(REG_CTRL2, 8'h0C);
    repeat (3) @(posedge ref_clk);
    check("sci_irq", 9'(sci_irq), 9'h000);
    wr(REG_DATA, 8'hA5);
    rd(REG_STATUS, 8'h00);
    wait_tx();
    check("tx word", node.got_word, 9'h0A5);
    check("tx stop", 9'(node.got_stop), 9'h001);
    node.send(9'h03C, 1'b0, 1'b1, -1);
    rd(REG_STATUS, 8'hE0);
    rd(REG_DATA, 8'h3C);
    repeat (12 * BITC) @(posedge ref_clk);
    rd(REG_STATUS, 8'hD0);
    rd(REG_DATA, 8'h3C);
    node.send(9'h055, 1'b0, 1'b1, 3);
    rd(REG_STATUS, 8'hE4);
    rd(REG_DATA, 8'h55);
    node.send(9'h066, 1'b0, 1'b1, 9);
    rd(REG_STATUS, 8'hE4);
    rd(REG_DATA, 8'h66);
    node.send(9'h0F0, 1'b0, 1'b0, -1);
    rd(REG_STATUS, 8'hE2);
    rd(REG_DATA, 8'hF0);
    node.send(9'h011, 1'b0, 1'b1, -1);
    node.send(9'h022, 1'b0, 1'b1, -1);
    rd(REG_STATUS, 8'hE8);
    rd(REG_DATA, 8'h11);
    wr(REG_CTRL1, 8'h50);
    nine <= 1'b1;
    wr(REG_DATA, 8'h81);
    wait_tx();
    check("tx word", node.got_word, 9'h181);
    node.send(9'h15A, 1'b1, 1'b1, -1);
    rd(REG_STATUS, 8'hF0);
    rd(REG_CTRL1, 8'hD0);
    rd(REG_DATA, 8'h5A);
    repeat (12 * BITC) @(posedge ref_clk);
    rd(REG_STATUS, 8'hD0);
    rd(REG_DATA, 8'h5A);
    wr(REG_CTRL1, 8'h00);
    nine <= 1'b0;
    wr(REG_CTRL2, 8'h0D);
    wait_tx();
    check("break", {node.got_stop, node.got_word[7:0]}, 9'h000);
    wr(REG_CTRL2, 8'h0C);
    repeat (15 * BITC) @(posedge ref_clk);
    wr(REG_DATA, 8'h3A);
    wait_tx();
    check("tx word", node.got_word, 9'h03A);
    repeat (BITC) @(posedge ref_clk);
    wr(REG_CTRL1, 8'h08);
    wr(REG_CTRL2, 8'h0E);
    node.send(9'h012, 1'b0, 1'b1, -1);
    rd(REG_STATUS, 8'hC0);
    node.send(9'h092, 1'b0, 1'b1, -1);
    rd(REG_STATUS, 8'hE0);
    rd(REG_DATA, 8'h92);
    rd(REG_CTRL2, 8'h0C);
    wr(REG_CTRL1, 8'h00);
    wr(REG_CTRL2, 8'h0E);
    node.send(9'h044, 1'b0, 1'b1, -1);
    rd(REG_STATUS, 8'hC0);
    repeat (12 * BITC) @(posedge ref_clk);
    rd(REG_CTRL2, 8'h0C);
    node.send(9'h077, 1'b0, 1'b1, -1);
    rd(REG_STATUS, 8'hE0);
    rd(REG_DATA, 8'h77);
    wr(REG_CTRL2, 8'h08);
    node.send(9'h033, 1'b0, 1'b1, -1);
    rd(REG_STATUS, 8'hC0);
    wr(REG_CTRL2, 8'h00);
    repeat (4) @(posedge ref_clk);
    check("tx_oe", 9'(serial_tx_oe), 9'h000);
    check("tx line", 9'(serial_tx_out), 9'h001);
    give_verdict();
  end
endmodule
